// ==== core/vp_defines.svh ====
// Shared constants of the video port tick, capture FIFO and display mode block.
`ifndef VP_DEFINES_SVH
`define VP_DEFINES_SVH

// Capture modes held in the port control register.
`define VP_CAP_BT656 2'h0
`define VP_CAP_YC 2'h1
`define VP_CAP_RAW 2'h2
`define VP_CAP_TS 2'h3

// Software register byte offsets.
`define VP_REG_PORT_CTL 5'h00
`define VP_REG_DISP_CTL 5'h04
`define VP_REG_STREAM_CTL 5'h08
`define VP_REG_IRQ_STAT 5'h0c
`define VP_REG_TICK_INT 5'h10
`define VP_REG_FIFO_STAT 5'h14

// Field positions.
`define VP_PC_CAPMODE 1:0
`define VP_PC_DUAL_DIS 2
`define VP_DC_MODE 2:0
`define VP_SC_TICK_EN 0
`define VP_SC_CNT_MODE 1
`define VP_IS_TICK 0
`define VP_FS_NONEMPTY 5:0

// Reset values.
`define VP_ZERO32 32'h0000_0000
`define VP_ZERO64 64'h0000_0000_0000_0000

// Capture FIFO geometry.
`define VP_WORD_W 64
`define VP_NUM_FIFO 6
`define VP_NUM_COLOR 3
`define VP_FIFO_DEPTH 3'h4
`define VP_PTR_W 2
`define VP_CNT_W 3

// Pseudo-register map on the link: channel base plus color offset.
`define VP_FIFO_BASE_A 8'h00
`define VP_FIFO_BASE_B 8'h20
`define VP_OFS_LUMA 8'h00
`define VP_OFS_BLUE 8'h08
`define VP_OFS_RED 8'h10

// Display mode codes.
`define VP_DM_BT656_8 3'h0
`define VP_DM_BT656_10 3'h1
`define VP_DM_RAW_8 3'h2
`define VP_DM_RAW_10 3'h3
`define VP_DM_YC_8 3'h4
`define VP_DM_YC_10 3'h5
`define VP_DM_RAW_16 3'h6
`define VP_DM_RAW_20 3'h7

// Display sample widths in bits.
`define VP_W8 5'h08
`define VP_W10 5'h0a
`define VP_W16 5'h10
`define VP_W20 5'h14

`endif

// ==== core/vp_pkg.sv ====
// Types shared by the video port ends.
`include "vp_defines.svh"
package vp_pkg;
	typedef logic [`VP_WORD_W-1:0] vp_word_type;
	typedef enum logic [1:0] {VP_DMA_IDLE, VP_DMA_REQ, VP_DMA_WAIT} vp_dma_state_type;
	typedef enum logic [1:0] {VP_DISP_MUX, VP_DISP_PARALLEL, VP_DISP_RAW} vp_disp_kind_type;
endpackage

// ==== core/vp_link.sv ====
// Link between the video port capture FIFOs and the DMA controller.
`timescale 1ns/1ps
`default_nettype none
interface vp_link;
	import vp_pkg::*;
	logic fifoRead;
	logic [7:0] fifoAddr;
	vp_word_type fifoData;
	logic fifoValid;
	logic [1:0] lumaDmaEvent;
	logic [1:0] blueChromaDmaEvent;
	logic [1:0] redChromaDmaEvent;

	// The video port answers reads and raises events.
	modport dev (
		input fifoRead, fifoAddr,
		output fifoData, fifoValid, lumaDmaEvent, blueChromaDmaEvent, redChromaDmaEvent
	);

	// The DMA controller issues reads.
	modport dma (
		output fifoRead, fifoAddr,
		input fifoData, fifoValid, lumaDmaEvent, blueChromaDmaEvent, redChromaDmaEvent
	);
endinterface
`default_nettype wire

// ==== core/vp_fifo.sv ====
// One capture FIFO of 64-bit words held in flip-flops.
`timescale 1ns/1ps
`default_nettype none
module vp_fifo
	import vp_pkg::*;
(
	// Clock and reset.
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic clkEn,
	// Fill side.
	input wire logic push,
	input wire vp_word_type pushData,
	// Drain side.
	input wire logic pop,
	output vp_word_type popData,
	// Fill level after this cycle.
	output logic [`VP_CNT_W-1:0] countNxt
);
	vp_word_type mem_r [`VP_FIFO_DEPTH];
	vp_word_type mem_nxt [`VP_FIFO_DEPTH];
	logic [`VP_PTR_W-1:0] wrPtr_r, wrPtr_nxt, rdPtr_r, rdPtr_nxt;
	logic [`VP_CNT_W-1:0] cnt_r;
	logic doPush, doPop;

	// A push into a full FIFO is dropped; the caller watches the full flag.
	always_comb begin
		doPush = push && (cnt_r != `VP_FIFO_DEPTH);
		doPop = pop && (cnt_r != '0);
		mem_nxt = mem_r;
		wrPtr_nxt = wrPtr_r;
		rdPtr_nxt = rdPtr_r;
		countNxt = cnt_r;
		if (doPush) begin
			mem_nxt[wrPtr_r] = pushData;
			wrPtr_nxt = wrPtr_r + 1'b1;
		end
		if (doPop) begin
			rdPtr_nxt = rdPtr_r + 1'b1;
		end
		if (doPush && !doPop) begin
			countNxt = cnt_r + 1'b1;
		end else if (doPop && !doPush) begin
			countNxt = cnt_r - 1'b1;
		end
	end

	// The oldest word always sits at the read pointer.
	assign popData = mem_r[rdPtr_r];

	// Storage and pointers.
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			for (int i = 0; i < `VP_FIFO_DEPTH; i++) begin
				mem_r[i] <= `VP_ZERO64;
			end
			wrPtr_r <= '0;
			rdPtr_r <= '0;
			cnt_r <= '0;
		end else if (clkEn) begin
			mem_r <= mem_nxt;
			wrPtr_r <= wrPtr_nxt;
			rdPtr_r <= rdPtr_nxt;
			cnt_r <= countNxt;
		end
	end
endmodule
`default_nettype wire

// ==== core/vp_device.sv ====
// Video port end: tick counter, capture FIFO pseudo-registers and display mode decode.
//
// How it works
// - Tick flag every count plus one clocks.
// - Tick counter ignores the counter mode bit.
// - Writing tick interval clears the counter.
// - On match set flag, counter back to zero.
// - Software disables tick before changing interval.
// - Tick interval 32-bit, resets zero, stream mode.
// - Luma, blue, red FIFOs at 00h, 08h, 10h.
// - Address is channel base plus offset.
// - Video modes raise three separate DMA events.
// - Raw mode raises only the luma event.
// - Raw and stream: chroma pseudo-registers unused.
// - FIFO words are 64 bits, read whole.
// - Three-bit display mode decodes eight formats.
// - Dual-channel modes refused while dual disable set.
// - Multiplexed stream or parallel luma and chroma.
//
// Added by the designer: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module vp_device
	import vp_pkg::*;
(
	// Clock, reset and freeze.
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic clkEn,
	// Software register port, Avalon-MM slave.
	input wire logic [4:0] avsAddress,
	input wire logic avsRead,
	input wire logic avsWrite,
	input wire logic [31:0] avsWriteData,
	input wire logic [3:0] avsByteEnable,
	output logic [31:0] avsReadData,
	output logic avsWaitRequest,
	// System time clock tick enable, one pulse per tick.
	input wire logic stcTick,
	// Capture data entry.
	input wire logic capPush,
	input wire logic [2:0] capSel,
	input wire vp_word_type capData,
	output logic [`VP_NUM_FIFO-1:0] capFull,
	// Decoded display mode and tick status.
	output vp_disp_kind_type dispKind,
	output logic [4:0] dispWidth,
	output logic tickStatus,
	// DMA side.
	vp_link.dev link
);
	logic [1:0] capMode_r, capMode_nxt;
	logic dualDis_r, dualDis_nxt;
	logic [2:0] dispMode_r, dispMode_nxt;
	logic tickEn_r, tickEn_nxt, cntMode_r, cntMode_nxt;
	logic tickFlag_r, tickFlag_nxt;
	logic [31:0] tickInt_r, tickInt_nxt, tickCnt_r, tickCnt_nxt;
	logic waitReq_r, waitReq_nxt;
	logic [31:0] readData_r, readData_nxt, readMux;
	logic wrTake;
	logic [`VP_NUM_FIFO-1:0] push, pop, capFull_r, capFull_nxt;
	logic [`VP_CNT_W-1:0] countNxt [`VP_NUM_FIFO];
	vp_word_type headData [`VP_NUM_FIFO];
	vp_word_type fifoData_r, fifoData_nxt;
	logic fifoValid_r, fifoValid_nxt;
	logic [1:0] lumaEvt_r, lumaEvt_nxt, blueEvt_r, blueEvt_nxt, redEvt_r, redEvt_nxt;
	logic [`VP_NUM_FIFO-1:0] nonEmpty;
	logic [3:0] hit;
	logic chromaOn;
	vp_disp_kind_type dispKind_r, dispKind_nxt;
	logic [4:0] dispWidth_r, dispWidth_nxt;

	// Merge write data into a register under the byte enables.
	function automatic logic [31:0] applyBe(input logic [31:0] old, input logic [31:0] wd,
			input logic [3:0] be);
		logic [31:0] res;
		res = old;
		for (int b = 0; b < 4; b++) begin
			if (be[b]) begin
				res[b*8 +: 8] = wd[b*8 +: 8];
			end
		end
		return res;
	endfunction

	// Modes that need both output channels are illegal with dual disable set.
	function automatic logic dispLegal(input logic [2:0] mode, input logic dis);
		return !(dis && (mode == `VP_DM_YC_8 || mode == `VP_DM_YC_10 ||
			mode == `VP_DM_RAW_16 || mode == `VP_DM_RAW_20));
	endfunction

	// Link address to {hit, FIFO index}; index is channel times three plus color.
	function automatic logic [3:0] decodeFifo(input logic [7:0] addr);
		logic [7:0] base;
		logic [7:0] ofs;
		logic [3:0] res;
		res = 4'h0;
		for (int c = 0; c < 2; c++) begin
			base = (c == 0) ? `VP_FIFO_BASE_A : `VP_FIFO_BASE_B;
			for (int k = 0; k < `VP_NUM_COLOR; k++) begin
				ofs = (k == 0) ? `VP_OFS_LUMA : (k == 1) ? `VP_OFS_BLUE : `VP_OFS_RED;
				if (addr == base + ofs) begin
					res = {1'b1, 3'(c * `VP_NUM_COLOR + k)};
				end
			end
		end
		return res;
	endfunction

	// Capture FIFOs, one per channel and color.
	generate
		for (genvar g = 0; g < `VP_NUM_FIFO; g++) begin : gFifo
			assign push[g] = capPush && (capSel == 3'(g));
			assign nonEmpty[g] = (countNxt[g] != '0);
			vp_fifo uFifo (
				.clock(clock),
				.sys_rst(sys_rst),
				.clkEn(clkEn),
				.push(push[g]),
				.pushData(capData),
				.pop(pop[g]),
				.popData(headData[g]),
				.countNxt(countNxt[g])
			);
		end
	endgenerate

	// Read multiplexer for the software registers; holes read zero.
	always_comb begin
		readMux = `VP_ZERO32;
		unique case (avsAddress)
			`VP_REG_PORT_CTL: begin
				readMux[`VP_PC_CAPMODE] = capMode_r;
				readMux[`VP_PC_DUAL_DIS] = dualDis_r;
			end
			`VP_REG_DISP_CTL: readMux[`VP_DC_MODE] = dispMode_r;
			`VP_REG_STREAM_CTL: begin
				readMux[`VP_SC_TICK_EN] = tickEn_r;
				readMux[`VP_SC_CNT_MODE] = cntMode_r;
			end
			`VP_REG_IRQ_STAT: readMux[`VP_IS_TICK] = tickFlag_r;
			`VP_REG_TICK_INT: readMux = tickInt_r;
			`VP_REG_FIFO_STAT: readMux[`VP_FS_NONEMPTY] = nonEmpty;
			default: readMux = `VP_ZERO32;
		endcase
	end

	// Register slave: wait one cycle, then answer; a write lands on the answer edge.
	always_comb begin
		wrTake = avsWrite && !waitReq_r;
		waitReq_nxt = 1'b1;
		readData_nxt = readData_r;
		if ((avsRead || avsWrite) && waitReq_r) begin
			waitReq_nxt = 1'b0;
			readData_nxt = readMux;
		end
		capMode_nxt = capMode_r;
		dualDis_nxt = dualDis_r;
		dispMode_nxt = dispMode_r;
		tickEn_nxt = tickEn_r;
		cntMode_nxt = cntMode_r;
		tickInt_nxt = tickInt_r;
		if (wrTake) begin
			unique case (avsAddress)
				`VP_REG_PORT_CTL: begin
					if (avsByteEnable[0]) begin
						capMode_nxt = avsWriteData[`VP_PC_CAPMODE];
						dualDis_nxt = avsWriteData[`VP_PC_DUAL_DIS];
					end
				end
				`VP_REG_DISP_CTL: begin
					if (avsByteEnable[0] &&
							dispLegal(avsWriteData[`VP_DC_MODE], dualDis_r)) begin
						dispMode_nxt = avsWriteData[`VP_DC_MODE];
					end
				end
				`VP_REG_STREAM_CTL: begin
					if (avsByteEnable[0]) begin
						tickEn_nxt = avsWriteData[`VP_SC_TICK_EN];
						cntMode_nxt = avsWriteData[`VP_SC_CNT_MODE];
					end
				end
				`VP_REG_TICK_INT: tickInt_nxt = applyBe(tickInt_r, avsWriteData, avsByteEnable);
				default: ;
			endcase
		end
	end

	// Tick counter runs on the tick enable in stream capture mode only, never on the counter mode bit.
	always_comb begin
		tickCnt_nxt = tickCnt_r;
		tickFlag_nxt = tickFlag_r;
		if (wrTake && avsAddress == `VP_REG_IRQ_STAT && avsByteEnable[0] &&
				avsWriteData[`VP_IS_TICK]) begin
			tickFlag_nxt = 1'b0;
		end
		if (stcTick && tickEn_r && capMode_r == `VP_CAP_TS) begin
			if (tickCnt_r == tickInt_r) begin
				tickFlag_nxt = 1'b1;
				tickCnt_nxt = `VP_ZERO32;
			end else begin
				tickCnt_nxt = tickCnt_r + 1'b1;
			end
		end
		if (wrTake && avsAddress == `VP_REG_TICK_INT) begin
			tickCnt_nxt = `VP_ZERO32;
		end
	end

	// Link reads: pop and answer next cycle; unused chroma reads return zero.
	always_comb begin
		chromaOn = (capMode_r == `VP_CAP_BT656) || (capMode_r == `VP_CAP_YC);
		hit = decodeFifo(link.fifoAddr);
		pop = '0;
		fifoValid_nxt = 1'b0;
		fifoData_nxt = fifoData_r;
		if (link.fifoRead) begin
			fifoValid_nxt = 1'b1;
			fifoData_nxt = `VP_ZERO64;
			if (hit[3] && (chromaOn || (hit[2:0] % `VP_NUM_COLOR) == 3'h0)) begin
				fifoData_nxt = headData[hit[2:0]];
				pop[hit[2:0]] = 1'b1;
			end
		end
		for (int c = 0; c < 2; c++) begin
			lumaEvt_nxt[c] = nonEmpty[c * `VP_NUM_COLOR];
			blueEvt_nxt[c] = chromaOn && nonEmpty[c * `VP_NUM_COLOR + 1];
			redEvt_nxt[c] = chromaOn && nonEmpty[c * `VP_NUM_COLOR + 2];
		end
		for (int f = 0; f < `VP_NUM_FIFO; f++) begin
			capFull_nxt[f] = (countNxt[f] == `VP_FIFO_DEPTH);
		end
	end

	// Display mode decode into stream layout and sample width.
	always_comb begin
		dispKind_nxt = VP_DISP_RAW;
		dispWidth_nxt = `VP_W8;
		unique case (dispMode_r)
			`VP_DM_BT656_8: dispKind_nxt = VP_DISP_MUX;
			`VP_DM_BT656_10: begin
				dispKind_nxt = VP_DISP_MUX;
				dispWidth_nxt = `VP_W10;
			end
			`VP_DM_RAW_8: dispWidth_nxt = `VP_W8;
			`VP_DM_RAW_10: dispWidth_nxt = `VP_W10;
			`VP_DM_YC_8: dispKind_nxt = VP_DISP_PARALLEL;
			`VP_DM_YC_10: begin
				dispKind_nxt = VP_DISP_PARALLEL;
				dispWidth_nxt = `VP_W10;
			end
			`VP_DM_RAW_16: dispWidth_nxt = `VP_W16;
			`VP_DM_RAW_20: dispWidth_nxt = `VP_W20;
		endcase
	end

	// All state freezes while the clock enable is low.
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			capMode_r <= `VP_CAP_BT656;
			dualDis_r <= 1'b0;
			dispMode_r <= `VP_DM_BT656_8;
			tickEn_r <= 1'b0;
			cntMode_r <= 1'b0;
			tickFlag_r <= 1'b0;
			tickInt_r <= `VP_ZERO32;
			tickCnt_r <= `VP_ZERO32;
			waitReq_r <= 1'b1;
			readData_r <= `VP_ZERO32;
			fifoData_r <= `VP_ZERO64;
			fifoValid_r <= 1'b0;
			lumaEvt_r <= '0;
			blueEvt_r <= '0;
			redEvt_r <= '0;
			capFull_r <= '0;
			dispKind_r <= VP_DISP_MUX;
			dispWidth_r <= `VP_W8;
		end else if (clkEn) begin
			capMode_r <= capMode_nxt;
			dualDis_r <= dualDis_nxt;
			dispMode_r <= dispMode_nxt;
			tickEn_r <= tickEn_nxt;
			cntMode_r <= cntMode_nxt;
			tickFlag_r <= tickFlag_nxt;
			tickInt_r <= tickInt_nxt;
			tickCnt_r <= tickCnt_nxt;
			waitReq_r <= waitReq_nxt;
			readData_r <= readData_nxt;
			fifoData_r <= fifoData_nxt;
			fifoValid_r <= fifoValid_nxt;
			lumaEvt_r <= lumaEvt_nxt;
			blueEvt_r <= blueEvt_nxt;
			redEvt_r <= redEvt_nxt;
			capFull_r <= capFull_nxt;
			dispKind_r <= dispKind_nxt;
			dispWidth_r <= dispWidth_nxt;
		end
	end

	// Every output comes straight from a flip-flop.
	assign avsReadData = readData_r;
	assign avsWaitRequest = waitReq_r;
	assign capFull = capFull_r;
	assign dispKind = dispKind_r;
	assign dispWidth = dispWidth_r;
	assign tickStatus = tickFlag_r;
	assign link.fifoData = fifoData_r;
	assign link.fifoValid = fifoValid_r;
	assign link.lumaDmaEvent = lumaEvt_r;
	assign link.blueChromaDmaEvent = blueEvt_r;
	assign link.redChromaDmaEvent = redEvt_r;
endmodule
`default_nettype wire

// ==== core/vp_dma.sv ====
// DMA controller end: serves FIFO events by reading whole 64-bit pseudo-registers.
`timescale 1ns/1ps
`default_nettype none
module vp_dma
	import vp_pkg::*;
(
	// Clock, reset and freeze.
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic clkEn,
	// Transfer enable.
	input wire logic dmaEnable,
	// Words delivered to memory.
	output vp_word_type outWord,
	output logic [2:0] outIndex,
	output logic outValid,
	output logic busy,
	// Video port side.
	vp_link.dma link
);
	vp_dma_state_type state_r, state_nxt;
	logic read_r, read_nxt, outValid_r, outValid_nxt;
	logic [7:0] addr_r, addr_nxt;
	logic [2:0] idx_r, idx_nxt;
	vp_word_type outWord_r, outWord_nxt;
	logic [`VP_NUM_FIFO-1:0] pend;
	logic found;

	// One read at a time; lowest pending index wins, so channel A luma goes first.
	always_comb begin
		state_nxt = state_r;
		read_nxt = 1'b0;
		addr_nxt = addr_r;
		idx_nxt = idx_r;
		outWord_nxt = outWord_r;
		outValid_nxt = 1'b0;
		found = 1'b0;
		for (int c = 0; c < 2; c++) begin
			pend[c * `VP_NUM_COLOR] = link.lumaDmaEvent[c];
			pend[c * `VP_NUM_COLOR + 1] = link.blueChromaDmaEvent[c];
			pend[c * `VP_NUM_COLOR + 2] = link.redChromaDmaEvent[c];
		end
		unique case (state_r)
			VP_DMA_IDLE: begin
				for (int f = 0; f < `VP_NUM_FIFO; f++) begin
					if (dmaEnable && pend[f] && !found) begin
						found = 1'b1;
						idx_nxt = 3'(f);
						addr_nxt = ((f / `VP_NUM_COLOR) == 0 ? `VP_FIFO_BASE_A : `VP_FIFO_BASE_B) +
							((f % `VP_NUM_COLOR) == 0 ? `VP_OFS_LUMA :
							(f % `VP_NUM_COLOR) == 1 ? `VP_OFS_BLUE : `VP_OFS_RED);
					end
				end
				if (found) begin
					read_nxt = 1'b1;
					state_nxt = VP_DMA_REQ;
				end
			end
			VP_DMA_REQ: state_nxt = VP_DMA_WAIT;
			VP_DMA_WAIT: begin
				if (link.fifoValid) begin
					outWord_nxt = link.fifoData;
					outValid_nxt = 1'b1;
					state_nxt = VP_DMA_IDLE;
				end
			end
			// The fourth code of the state word is never entered; recover to idle.
			default: state_nxt = VP_DMA_IDLE;
		endcase
	end

	// State and outputs, frozen while the clock enable is low.
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			state_r <= VP_DMA_IDLE;
			read_r <= 1'b0;
			addr_r <= `VP_FIFO_BASE_A;
			idx_r <= 3'h0;
			outWord_r <= `VP_ZERO64;
			outValid_r <= 1'b0;
		end else if (clkEn) begin
			state_r <= state_nxt;
			read_r <= read_nxt;
			addr_r <= addr_nxt;
			idx_r <= idx_nxt;
			outWord_r <= outWord_nxt;
			outValid_r <= outValid_nxt;
		end
	end

	// Busy is a flop copy of the state so that it stays glitch free.
	logic busy_r;
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			busy_r <= 1'b0;
		end else if (clkEn) begin
			busy_r <= (state_nxt != VP_DMA_IDLE);
		end
	end

	assign link.fifoRead = read_r;
	assign link.fifoAddr = addr_r;
	assign outWord = outWord_r;
	assign outIndex = idx_r;
	assign outValid = outValid_r;
	assign busy = busy_r;
endmodule
`default_nettype wire

// ==== sim/vp_checker.sv ====
// Concurrent checks on the link between the capture FIFOs and the DMA controller.
`timescale 1ns/1ps
`default_nettype none
module vp_checker
	import vp_pkg::*;
(
	// Clock and reset.
	input wire logic clock,
	input wire logic sys_rst,
	// Link signals.
	input wire logic fifoRead,
	input wire logic [7:0] fifoAddr,
	input wire vp_word_type fifoData,
	input wire logic fifoValid,
	input wire logic [1:0] lumaDmaEvent,
	input wire logic [1:0] blueChromaDmaEvent,
	input wire logic [1:0] redChromaDmaEvent
);
	logic addrEvt;
	logic [5:0] allEvt;

	// Event line of the addressed pseudo-register, so a read can be tied to its cause.
	always_comb begin
		case (fifoAddr[4:3])
			2'h0: addrEvt = lumaDmaEvent[fifoAddr[5]];
			2'h1: addrEvt = blueChromaDmaEvent[fifoAddr[5]];
			default: addrEvt = redChromaDmaEvent[fifoAddr[5]];
		endcase
	end
	assign allEvt = {redChromaDmaEvent, blueChromaDmaEvent, lumaDmaEvent};

	// One clock domain, so clock and reset are declared once for every property.
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (sys_rst);

	chk_read_answered: assert property (fifoRead |=> fifoValid)
		else $error("fifo read not answered in the next cycle");
	chk_valid_caused: assert property (fifoValid |-> $past(fifoRead))
		else $error("fifo answer without a read");
	chk_valid_single: assert property (fifoValid |=> !fifoValid)
		else $error("fifo answer longer than one cycle");
	chk_read_spaced: assert property (fifoRead |=> !fifoRead)
		else $error("second read before the answer");
	chk_read_alone: assert property (fifoRead |-> !fifoValid)
		else $error("read issued in an answer cycle");
	chk_addr_mapped: assert property (fifoRead |->
		fifoAddr inside {8'h00, 8'h08, 8'h10, 8'h20, 8'h28, 8'h30})
		else $error("read outside the pseudo-registers");
	chk_read_on_event: assert property (fifoRead |-> addrEvt)
		else $error("read of a fifo whose event is low");
	chk_data_held: assert property (!fifoValid |-> $stable(fifoData))
		else $error("fifo data changed without an answer");
	chk_event_drop: assert property ((|($past(allEvt) & ~allEvt)) |-> fifoValid)
		else $error("fifo event fell without a pop");

	// Main traffic shapes that the bench should reach.
	cover property (fifoRead && fifoAddr == 8'h30);
	cover property (lumaDmaEvent[0] && blueChromaDmaEvent[1]);
	cover property (fifoValid ##2 fifoRead);
endmodule
`default_nettype wire

// ==== sim/tb_top.sv ====
// Self-checking bench for the video port and its DMA controller joined by the link.
`timescale 1ns/1ps
`default_nettype none
`include "vp_defines.svh"
module tb_top;
	import vp_pkg::*;
	typedef struct {logic [2:0] mode; vp_disp_kind_type kind; logic [4:0] width;} vp_row_type;
	logic clock = 1'b0;
	logic sys_rst = 1'b1;
	logic clkEn = 1'b1;
	logic [4:0] avsAddress = 5'h00;
	logic avsRead = 1'b0;
	logic avsWrite = 1'b0;
	logic [31:0] avsWriteData = 32'h0000_0000;
	logic [3:0] avsByteEnable = 4'hf;
	logic [31:0] avsReadData;
	logic avsWaitRequest;
	logic stcTick = 1'b0;
	logic capPush = 1'b0;
	logic [2:0] capSel = 3'h0;
	vp_word_type capData = `VP_ZERO64;
	logic [5:0] capFull;
	vp_disp_kind_type dispKind;
	logic [4:0] dispWidth;
	logic tickStatus;
	logic dmaEnable = 1'b0;
	vp_word_type outWord;
	logic [2:0] outIndex;
	logic outValid;
	logic busy;
	int bad_count = 0;
	int samples_checked = 0;
	logic [31:0] rd;
	vp_word_type expQ[$];
	logic [2:0] idxQ[$];
	vp_row_type rows[8] = '{'{3'h0, VP_DISP_MUX, 5'h08}, '{3'h1, VP_DISP_MUX, 5'h0a},
		'{3'h2, VP_DISP_RAW, 5'h08}, '{3'h3, VP_DISP_RAW, 5'h0a},
		'{3'h4, VP_DISP_PARALLEL, 5'h08}, '{3'h5, VP_DISP_PARALLEL, 5'h0a},
		'{3'h6, VP_DISP_RAW, 5'h10}, '{3'h7, VP_DISP_RAW, 5'h14}};

	// Both ends meet on one link; the checker watches it.
	vp_link i_vp_link();
	vp_device i_vp_device(.clock(clock), .sys_rst(sys_rst), .clkEn(clkEn),
		.avsAddress(avsAddress), .avsRead(avsRead), .avsWrite(avsWrite),
		.avsWriteData(avsWriteData), .avsByteEnable(avsByteEnable),
		.avsReadData(avsReadData), .avsWaitRequest(avsWaitRequest), .stcTick(stcTick),
		.capPush(capPush), .capSel(capSel), .capData(capData), .capFull(capFull),
		.dispKind(dispKind), .dispWidth(dispWidth), .tickStatus(tickStatus),
		.link(i_vp_link.dev));
	vp_dma i_vp_dma(.clock(clock), .sys_rst(sys_rst), .clkEn(clkEn), .dmaEnable(dmaEnable),
		.outWord(outWord), .outIndex(outIndex), .outValid(outValid), .busy(busy),
		.link(i_vp_link.dma));
	vp_checker i_vp_checker(.clock(clock), .sys_rst(sys_rst), .fifoRead(i_vp_link.fifoRead),
		.fifoAddr(i_vp_link.fifoAddr), .fifoData(i_vp_link.fifoData),
		.fifoValid(i_vp_link.fifoValid), .lumaDmaEvent(i_vp_link.lumaDmaEvent),
		.blueChromaDmaEvent(i_vp_link.blueChromaDmaEvent),
		.redChromaDmaEvent(i_vp_link.redChromaDmaEvent));

	// Free-running 100 MHz clock.
	always #5 clock = ~clock;

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask

	task automatic cmp(input logic [63:0] got, input logic [63:0] exp, input string what);
		samples_checked++;
		if (got !== exp) begin
			$display("[FAIL] %0t %s", $time, what);
			bad_count++;
		end
	endtask

	// One Avalon access; the request is held until waitrequest is sampled low.
	task automatic busOp(input logic wr, input logic [4:0] a, input logic [31:0] d);
		int n;
		n = 0;
		avsAddress <= a;
		avsWriteData <= d;
		avsWrite <= wr;
		avsRead <= !wr;
		do begin
			@(posedge clock);
			n++;
		end while (avsWaitRequest !== 1'b0 && n < 50);
		rd = avsReadData;
		avsWrite <= 1'b0;
		avsRead <= 1'b0;
		if (avsWaitRequest !== 1'b0) begin
			cmp(1'b0, 1'b1, "bus timeout");
			wrap_up();
		end
		@(posedge clock);
	endtask

	// Each tick is one high cycle followed by a gap long enough for the flag copy.
	task automatic ticks(input int n);
		repeat (n) begin
			stcTick <= 1'b1;
			@(posedge clock);
			stcTick <= 1'b0;
			repeat (3) @(posedge clock);
		end
	endtask

	task automatic push(input int s, input int q);
		capPush <= 1'b1;
		capSel <= 3'(s);
		capData <= {32'hFACE_0000, 8'h00, 8'(q), 13'h0000, 3'(s)};
		@(posedge clock);
		capPush <= 1'b0;
		@(posedge clock);
	endtask

	// Lets the DMA run and matches every delivered word; stray words are mismatches.
	task automatic drain();
		int n;
		int quiet;
		n = 0;
		quiet = 0;
		dmaEnable <= 1'b1;
		while ((idxQ.size() > 0 || quiet < 30) && n < 600) begin
			@(posedge clock);
			n++;
			if (idxQ.size() == 0) quiet++;
			if (outValid === 1'b1) begin
				if (idxQ.size() == 0) cmp(1'b1, 1'b0, "unexpected dma word");
				else begin
					cmp(outIndex, idxQ.pop_front(), "dma fifo index");
					cmp(outWord, expQ.pop_front(), "dma word order");
					cmp(busy, 1'b0, "dma busy with word out");
				end
			end
		end
		dmaEnable <= 1'b0;
		if (idxQ.size() > 0) begin
			cmp(1'b0, 1'b1, "dma timeout");
			wrap_up();
		end
	endtask

	task automatic expectWord(input int s, input int q);
		idxQ.push_back(3'(s));
		expQ.push_back({32'hFACE_0000, 8'h00, 8'(q), 13'h0000, 3'(s)});
	endtask

	initial begin
		repeat (3) @(posedge clock);
		sys_rst <= 1'b0;
		@(posedge clock);
		// Every register reads zero after reset, unmapped words included.
		for (int a = 0; a < 32; a += 4) begin
			busOp(1'b0, 5'(a), 32'h0000_0000);
			cmp(rd, 32'h0000_0000, "reset value");
		end
		// Display mode table.
		foreach (rows[i]) begin
			busOp(1'b1, 5'h04, {29'h0000_0000, rows[i].mode});
			busOp(1'b0, 5'h04, 32'h0000_0000);
			cmp(rd[2:0], rows[i].mode, "display mode readback");
			cmp(dispKind, rows[i].kind, "display kind");
			cmp(dispWidth, rows[i].width, "display width");
		end
		$display("display table done");
		// With dual channel disabled the wide and parallel modes are refused.
		busOp(1'b1, 5'h00, 32'h0000_0004);
		busOp(1'b1, 5'h04, 32'h0000_0003);
		for (int m = 4; m < 8; m++) begin
			busOp(1'b1, 5'h04, 32'(m));
			busOp(1'b0, 5'h04, 32'h0000_0000);
			cmp(rd, 32'h0000_0003, "refused display mode");
			cmp(dispWidth, 5'h0a, "refused display width");
		end
		busOp(1'b1, 5'h00, 32'h0000_0000);
		$display("dual disable done");
		// Tick counter in stream mode, counter mode bit set to show it has no effect.
		busOp(1'b1, 5'h10, 32'hDEAD_BEEF);
		busOp(1'b0, 5'h10, 32'h0000_0000);
		cmp(rd, 32'hDEAD_BEEF, "tick interval readback");
		busOp(1'b1, 5'h00, 32'h0000_0003);
		busOp(1'b1, 5'h10, 32'h0000_0003);
		busOp(1'b1, 5'h08, 32'h0000_0003);
		ticks(3);
		cmp(tickStatus, 1'b0, "tick too early");
		ticks(1);
		cmp(tickStatus, 1'b1, "tick missing");
		// Three ticks stop one short of the next wrap, so only a sticky flag reads high.
		ticks(3);
		cmp(tickStatus, 1'b1, "tick flag not sticky");
		busOp(1'b1, 5'h0c, 32'h0000_0001);
		busOp(1'b0, 5'h0c, 32'h0000_0000);
		cmp(rd, 32'h0000_0000, "tick flag not cleared");
		// Software stops the tick before it rewrites the interval.
		busOp(1'b1, 5'h08, 32'h0000_0000);
		busOp(1'b1, 5'h10, 32'h0000_0003);
		busOp(1'b1, 5'h08, 32'h0000_0003);
		ticks(3);
		cmp(tickStatus, 1'b0, "interval write kept the count");
		ticks(1);
		cmp(tickStatus, 1'b1, "tick after restart");
		busOp(1'b1, 5'h0c, 32'h0000_0001);
		busOp(1'b1, 5'h00, 32'h0000_0000);
		ticks(6);
		cmp(tickStatus, 1'b0, "tick outside stream mode");
		busOp(1'b1, 5'h08, 32'h0000_0000);
		$display("tick counter done");
		// Fill all six fifos, one twice and one past full, then drain oldest first.
		for (int i = 0; i < 6; i++) begin
			for (int q = 0; q < ((i == 0) ? 2 : (i == 3) ? 5 : 1); q++) begin
				push(i, q);
				if (q < 4) expectWord(i, q);
			end
		end
		cmp(capFull, 6'h08, "fifo full flags");
		cmp({i_vp_link.redChromaDmaEvent, i_vp_link.blueChromaDmaEvent,
			i_vp_link.lumaDmaEvent}, 6'h3f, "video mode events");
		busOp(1'b0, 5'h14, 32'h0000_0000);
		cmp(rd, 32'h0000_003f, "fifo status");
		drain();
		busOp(1'b0, 5'h14, 32'h0000_0000);
		cmp(rd, 32'h0000_0000, "fifos not empty");
		$display("video mode fifos done");
		// Raw mode raises only the luma event, so the chroma word is never fetched.
		busOp(1'b1, 5'h00, 32'h0000_0002);
		push(0, 9);
		push(1, 9);
		expectWord(0, 9);
		cmp(i_vp_link.lumaDmaEvent, 2'h1, "raw luma event");
		cmp(i_vp_link.blueChromaDmaEvent, 2'h0, "raw chroma event");
		drain();
		$display("raw mode done");
		// A push while the clock enable is low must leave every FIFO as it was.
		clkEn <= 1'b0;
		push(0, 7);
		clkEn <= 1'b1;
		busOp(1'b0, 5'h14, 32'h0000_0000);
		cmp(rd, 32'h0000_0002, "push taken while frozen");
		$display("clock enable done");
		// Reset in mid-run with a word still held.
		sys_rst <= 1'b1;
		repeat (3) @(posedge clock);
		cmp(avsWaitRequest, 1'b1, "waitrequest in reset");
		cmp(dispWidth, 5'h08, "width in reset");
		cmp(i_vp_link.blueChromaDmaEvent, 2'h0, "event in reset");
		sys_rst <= 1'b0;
		@(posedge clock);
		busOp(1'b0, 5'h14, 32'h0000_0000);
		cmp(rd, 32'h0000_0000, "fifos after reset");
		busOp(1'b0, 5'h10, 32'h0000_0000);
		cmp(rd, 32'h0000_0000, "interval after reset");
		$display("second reset done");
		wrap_up();
	end
endmodule
`default_nettype wire
